// >>> pkg/adms_regs.svh
// adms_regs.svh: offsets, field positions, reset values and timing counts
// assumes a 50 MHz ref clock and byte offsets on a plain register port
// Functional notes
// - idle sequencer loops fetching octal 003 until attention dispatch reports an event.
// - control store is 512 by 44 bits; word register loads every 200 ns.
// - control word bits 8:0 are the next-address field feeding the store address.
// - next address is the field, field plus offset, or the attention entry address.
// - store output only acts once captured into the control word register.
// - six-bit branch field splits into group digit and select digit.
// - codes 0 to 27 add one to the field when the condition holds.
// - two-way selects 10 to 17: address bit 1 through purge required.
// - two-way selects 20 to 27 as listed; 22 spare.
// - codes 40 to 52 add a two-bit offset from two conditions.
// - four-way 40 to 45 pairs: path address, data 31:30, attention, confirmation, address.
// - four-way 46, 47, 51, 52 pairs as listed; 44 and 50 spare.
// - confirmation bits mean none, acknowledge, busy, error.
// - data path register write bits 31:30 select none, clear flag, purge, both.
// - codes 60 to 65 produce strobes; only 60 also branches, to the attention entry; 66, 67 spare.
// - codes 70 and 71 add three- and four-bit offsets from byte offset and address bits.
// - sixteen-bit operation field splits into eight two-bit selects.
// - buffered path number comes from map bits, register address, zero or counter.
// - eight-state bus counter idles at zero, requests, takes grant, steps protocol.
// - bus counter asks for sequencer attention only on read accesses.
// - software writes finish without the sequencer; other work runs as microroutines.
// - configuration or diagnostic register write enables strobes; fault enables fault logic.
// - idle word holds next address 003, code 60, map select 2, field A 17.
// - code 63 loads twelve bits into register A; 64 loads four into B.
`ifndef ADMS_REGS_SVH
`define ADMS_REGS_SVH
`define ADMS_CLK_NS    20
`define ADMS_CYC_NS    200
`define ADMS_CYC_CNT   ((`ADMS_CYC_NS + `ADMS_CLK_NS - 1) / `ADMS_CLK_NS)
`define ADMS_IDLE_ADDR 9'h003
`define ADMS_IDLE_WORD 44'h00f_0008_6003
`define ADMS_PRD_ENTRY 9'h040
`define ADMS_OFS_INDEX 8'h00
`define ADMS_OFS_LO    8'h04
`define ADMS_OFS_HI    8'h08
`define ADMS_OFS_STAT  8'h0c
`define ADMS_OFS_CTRL  8'h10
`define ADMS_OFS_DPW   8'h14
`define ADMS_OFS_CFG   8'h18
`define ADMS_OFS_DIAG  8'h1c
`define ADMS_BSS_LSB   0
`define ADMS_MWS_LSB   2
`endif

// >>> pkg/adms_pkg.sv
// adms_pkg: types shared by the microsequencer and its surroundings
// assumes condition inputs come from logic on the same clock
package adms_pkg;
    typedef struct packed {
        logic       bp_req;
        logic       dp_nonzero;
        logic       ext_func;
        logic       data_xfer;
        logic       bdp_active;
        logic       ack;
        logic [2:0] addr;
        logic       msyn_rlsd;
        logic       parity_err;
        logic       io_page;
        logic       byte_off;
        logic       rd_failsafe;
        logic       purge_ok;
        logic       purge_rqd;
        logic       cnt_full;
        logic       transmit_parity_bit;
        logic [2:0] pa_sel;
        logic [2:0] ba_sel;
        logic       vec_full;
        logic       intr_rlsd;
        logic [1:0] path_addr;
        logic [1:0] bp_data_hi;
        logic [1:0] conf;
        logic       pf_rcvd;
        logic       rd_rcvd;
        logic [3:0] map_dp;
        logic [3:0] reg_addr;
        logic [4:1] tcnt;
    } adms_cond_t;
    typedef struct packed {
        logic [11:0] uc;
        logic [15:0] op;
        logic        spare;
        logic [5:0]  br;
        logic [8:0]  next_address_field;
    } adms_cw_t;
    typedef struct packed {
        logic att_sel;
        logic chg_mask;
        logic chg_state;
        logic ld_opa;
        logic ld_opb;
        logic mask_clr_dma;
    } adms_strb_t;
    typedef enum logic [2:0] {
        PB_IDLE = 3'b001,
        PB_REQ  = 3'b010,
        PB_MAST = 3'b100
    } adms_pb_t;
endpackage

// >>> core/adms_seq.sv
// adms_seq: microsequencer, control store, next-address logic, bus counter
// assumes a plain register port and a grant pin from the bus terminator
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "adms_regs.svh"
module adms_seq
    import adms_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire adms_cond_t  cond_in,
    input  wire logic        att_req_in,
    input  wire logic [8:0]  att_entry_in,
    input  wire logic        opreg_clr_in,
    input  wire logic        sw_xfer_in,
    input  wire logic        sw_read_in,
    input  wire logic        npg_in,
    input  wire logic        fault_in,
    output logic             npr_out,
    output logic             pb_master_out,
    output logic      [2:0]  pb_count_out,
    output adms_cw_t         cw_out,
    output logic      [8:0]  cs_addr_out,
    output adms_strb_t       strb_out,
    output logic      [11:0] opa_out,
    output logic      [3:0]  opb_out,
    output logic      [3:0]  bdp_num_out,
    output logic             clr_xfer_err_out,
    output logic             purge_out,
    output logic             reg_strobe_en_out,
    output logic             fault_en_out
);
    localparam logic [3:0] CYC_LAST = 4'(`ADMS_CYC_CNT - 1);

    logic [43:0] mem [0:511];
    adms_cw_t    cw_r;
    logic [8:0]  cs_addr_r;
    logic [8:0]  nxt;
    logic        att_take;
    logic [3:0]  cyc_r;
    logic        tick;
    logic        tick_d_r;
    logic        boot_r;
    logic        run_r;
    logic        pattn_r;
    logic        pattn_set;
    logic [8:0]  idx_r;
    logic [31:0] lo_r;
    logic [31:0] rdata_r;
    adms_strb_t  strb_r;
    logic [11:0] opa_r;
    logic [3:0]  opb_r;
    logic [3:0]  bdp_r;
    logic        clr_r;
    logic        purge_r;
    logic        rse_r;
    logic        fen_r;
    logic        npg_m_r;
    logic        npg_s_r;
    adms_pb_t    st_r;
    logic [2:0]  pc_r;
    logic        rd_pend_r;
    logic        wr_hit;

    // two-way condition by select code
    function automatic logic cond2(input logic [4:0] s, input adms_cond_t c,
                                   input logic [1:0] ms);
        logic v;
        v = 1'b0;
        unique case (s)
            5'o00: v = 1'b0;
            5'o01: v = c.bp_req;
            5'o02: v = c.dp_nonzero;
            5'o03: v = c.ext_func;
            5'o04: v = c.data_xfer;
            5'o06: v = c.bdp_active;
            5'o07: v = c.ack;
            5'o10: v = c.addr[1];
            5'o11: v = c.msyn_rlsd;
            5'o12: v = c.parity_err;
            5'o13: v = c.io_page;
            5'o14: v = c.byte_off;
            5'o15: v = c.rd_failsafe;
            5'o16: v = c.purge_ok;
            5'o17: v = c.purge_rqd;
            5'o20: v = c.tcnt[4];
            5'o21: v = c.cnt_full;
            5'o23: v = c.transmit_parity_bit;
            5'o24: v = c.pa_sel[2];
            5'o25: v = c.ba_sel[2];
            5'o26: v = c.vec_full;
            5'o27: v = c.intr_rlsd;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // four-way offset by select code; ms is the micro-state pair
    function automatic logic [1:0] cond4(input logic [3:0] s, input adms_cond_t c,
                                         input logic [1:0] ms);
        logic [1:0] v;
        v = 2'b00;
        unique case (s)
            4'o00: v = c.path_addr;
            4'o01: v = c.bp_data_hi;
            4'o02: v = c.pa_sel[1:0];
            4'o03: v = c.conf;
            4'o05: v = c.addr[1:0];
            4'o06: v = {c.pf_rcvd, c.rd_failsafe};
            4'o07: v = {c.rd_rcvd, c.rd_failsafe};
            4'o11: v = ms;
            4'o12: v = c.ba_sel[1:0];
            default: v = 2'b00;
        endcase
        return v;
    endfunction

    // next-address selection; sums wrap in nine bits
    always_comb begin
        nxt = cw_r.next_address_field;
        att_take = 1'b0;
        if (boot_r) begin
            nxt = `ADMS_IDLE_ADDR;
        end else if (cw_r.br <= 6'o27) begin
            nxt = cw_r.next_address_field + {8'h00, cond2(cw_r.br[4:0], cond_in, opa_r[11:10])};
        end else if (cw_r.br >= 6'o40 && cw_r.br <= 6'o52) begin
            nxt = cw_r.next_address_field + {7'h00, cond4(cw_r.br[3:0], cond_in, opa_r[11:10])};
        end else if (cw_r.br == 6'o60 && (pattn_r || att_req_in)) begin
            att_take = 1'b1;
            nxt = pattn_r ? `ADMS_PRD_ENTRY : att_entry_in;
        end else if (cw_r.br == 6'o70) begin
            nxt = cw_r.next_address_field + {5'h00, 1'b0, cond_in.byte_off, cond_in.addr[2:1]};
        end else if (cw_r.br == 6'o71) begin
            nxt = cw_r.next_address_field + {5'h00, cond_in.byte_off, cond_in.addr};
        end
    end

    // one backplane cycle is several clocks
    assign tick = ce_in && run_r && (cyc_r == CYC_LAST);

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cyc_r <= 4'h0;
        end else if (ce_in) begin
            cyc_r <= (cyc_r == CYC_LAST) ? 4'h0 : cyc_r + 4'h1;
        end
    end

    // location 003 is wired so the idle loop never depends on loading
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cw_r <= '0;
            cs_addr_r <= `ADMS_IDLE_ADDR;
            boot_r <= 1'b1;
        end else if (tick) begin
            cw_r <= (nxt == `ADMS_IDLE_ADDR) ? `ADMS_IDLE_WORD : mem[nxt];
            cs_addr_r <= nxt;
            boot_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tick_d_r <= 1'b0;
        end else if (ce_in) begin
            tick_d_r <= tick;
        end
    end

    // strobes fire once, the clock after the word is captured
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            strb_r <= '0;
        end else if (ce_in) begin
            strb_r <= '0;
            if (tick_d_r) begin
                strb_r.att_sel <= (cw_r.br == 6'o60);
                strb_r.chg_mask <= (cw_r.br == 6'o61);
                strb_r.chg_state <= (cw_r.br == 6'o62);
                strb_r.ld_opa <= (cw_r.br == 6'o63);
                strb_r.ld_opb <= (cw_r.br == 6'o64);
                strb_r.mask_clr_dma <= (cw_r.br == 6'o65);
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || opreg_clr_in) begin
            opa_r <= 12'h000;
            opb_r <= 4'h0;
        end else if (ce_in && tick_d_r) begin
            if (cw_r.br == 6'o63) begin
                opa_r <= {cw_r.op[15:5], cw_r.op[2]};
            end
            if (cw_r.br == 6'o64) begin
                opb_r <= cw_r.op[15:12];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            bdp_r <= 4'h0;
        end else if (ce_in) begin
            unique case (cw_r.op[`ADMS_BSS_LSB +: 2])
                2'd0: bdp_r <= cond_in.map_dp;
                2'd1: bdp_r <= cond_in.reg_addr;
                2'd2: bdp_r <= 4'h0;
                2'd3: bdp_r <= cond_in.tcnt;
            endcase
        end
    end

    // grant comes from another bus; two flops before use
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            npg_m_r <= 1'b0;
            npg_s_r <= 1'b0;
        end else if (ce_in) begin
            npg_m_r <= npg_in;
            npg_s_r <= npg_m_r;
        end
    end

    // writes leave without the sequencer; only reads come back
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_r <= PB_IDLE;
            pc_r <= 3'h0;
            rd_pend_r <= 1'b0;
        end else if (ce_in) begin
            unique case (st_r)
                PB_IDLE: begin
                    pc_r <= 3'h0;
                    if (sw_xfer_in) begin
                        st_r <= PB_REQ;
                        rd_pend_r <= sw_read_in;
                    end
                end
                PB_REQ: begin
                    if (npg_s_r) begin
                        st_r <= PB_MAST;
                        pc_r <= 3'h1;
                    end
                end
                PB_MAST: begin
                    pc_r <= pc_r + 3'h1;
                    if (pc_r == 3'h7) begin
                        st_r <= PB_IDLE;
                    end
                end
                default: st_r <= PB_IDLE;
            endcase
        end
    end

    assign pattn_set = (st_r == PB_MAST) && (pc_r == 3'h7) && rd_pend_r;

    // set wins over the dispatch clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pattn_r <= 1'b0;
        end else if (ce_in) begin
            if (pattn_set) begin
                pattn_r <= 1'b1;
            end else if (tick && att_take) begin
                pattn_r <= 1'b0;
            end
        end
    end

    // register port; store loads low word then high word
    assign wr_hit = ce_in && reg_wr_in;

    always_ff @(posedge ref_clk_in) begin
        if (wr_hit && reg_addr_in == `ADMS_OFS_HI) begin
            mem[idx_r] <= {reg_wdata_in[11:0], lo_r};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            idx_r <= 9'h000;
            lo_r <= 32'h0000_0000;
            run_r <= 1'b1;
        end else if (wr_hit) begin
            if (reg_addr_in == `ADMS_OFS_INDEX) begin
                idx_r <= reg_wdata_in[8:0];
            end
            if (reg_addr_in == `ADMS_OFS_LO) begin
                lo_r <= reg_wdata_in;
            end
            if (reg_addr_in == `ADMS_OFS_HI) begin
                idx_r <= idx_r + 9'h001;
            end
            if (reg_addr_in == `ADMS_OFS_CTRL) begin
                run_r <= reg_wdata_in[0];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            clr_r <= 1'b0;
            purge_r <= 1'b0;
            rse_r <= 1'b0;
            fen_r <= 1'b0;
        end else if (ce_in) begin
            clr_r <= reg_wr_in && reg_addr_in == `ADMS_OFS_DPW && reg_wdata_in[30];
            purge_r <= reg_wr_in && reg_addr_in == `ADMS_OFS_DPW && reg_wdata_in[31];
            rse_r <= reg_wr_in && (reg_addr_in == `ADMS_OFS_CFG ||
                                   reg_addr_in == `ADMS_OFS_DIAG);
            fen_r <= fault_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            rdata_r <= 32'h0000_0000;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    `ADMS_OFS_INDEX: rdata_r <= {23'h000000, idx_r};
                    `ADMS_OFS_LO:    rdata_r <= lo_r;
                    `ADMS_OFS_STAT:  rdata_r <= {16'h0000, pattn_r, st_r, pc_r, cs_addr_r};
                    `ADMS_OFS_CTRL:  rdata_r <= {31'h00000000, run_r};
                    default:         rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign reg_rdata_out = rdata_r;
    assign cw_out = cw_r;
    assign cs_addr_out = cs_addr_r;
    assign strb_out = strb_r;
    assign opa_out = opa_r;
    assign opb_out = opb_r;
    assign bdp_num_out = bdp_r;
    assign npr_out = (st_r == PB_REQ);
    assign pb_master_out = (st_r == PB_MAST);
    assign pb_count_out = pc_r;
    assign clr_xfer_err_out = clr_r;
    assign purge_out = purge_r;
    assign reg_strobe_en_out = rse_r;
    assign fault_en_out = fen_r;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_grant;
        ce_in && st_r == PB_REQ && npg_s_r;
    endsequence
    sequence s_last_read;
        ce_in && st_r == PB_MAST && pc_r == 3'h7 && rd_pend_r;
    endsequence

    property p_idle_loop;
        !boot_r && cw_r.br == 6'o60 && cw_r.next_address_field == 9'h003 && !pattn_r && !att_req_in
            |-> nxt == 9'h003;
    endproperty
    a_idle_loop: assert property (p_idle_loop) else $error("idle loop left 003");
    property p_cw_tick;
        $changed(cw_r) |-> $past(tick);
    endproperty
    a_cw_tick: assert property (p_cw_tick) else $error("word changed off cycle");
    property p_addr_take;
        tick |=> cs_addr_r == $past(nxt);
    endproperty
    a_addr_take: assert property (p_addr_take) else $error("address not taken");
    property p_never;
        !boot_r && cw_r.br == 6'o00 |-> nxt == cw_r.next_address_field;
    endproperty
    a_never: assert property (p_never) else $error("never branch moved");
    property p_opa;
        ce_in && tick_d_r && cw_r.br == 6'o63 && !opreg_clr_in
            |=> opa_r == {$past(cw_r.op[15:5]), $past(cw_r.op[2])};
    endproperty
    a_opa: assert property (p_opa) else $error("register A load wrong");
    property p_opb_hold;
        !(tick_d_r && cw_r.br == 6'o64) && !opreg_clr_in |=> $stable(opb_r);
    endproperty
    a_opb_hold: assert property (p_opb_hold) else $error("register B drifted");
    property p_pb_idle;
        st_r == PB_IDLE && !$past(pb_master_out) |-> pc_r == 3'h0;
    endproperty
    a_pb_idle: assert property (p_pb_idle) else $error("counter not zero");
    property p_grant;
        s_grant |=> pb_master_out && pc_r == 3'h1 && !npr_out;
    endproperty
    a_grant: assert property (p_grant) else $error("grant not taken");
    property p_rd_att;
        s_last_read |=> pattn_r ##0 st_r == PB_IDLE;
    endproperty
    a_rd_att: assert property (p_rd_att) else $error("read attention lost");
    property p_dpw;
        ce_in && reg_wr_in && reg_addr_in == `ADMS_OFS_DPW && reg_wdata_in[31:30] == 2'b11
            |=> clr_xfer_err_out && purge_out ##1 !purge_out;
    endproperty
    a_dpw: assert property (p_dpw) else $error("data path action wrong");
endmodule

// >>> verif/adms_term_model.sv
// adms_term_model: bus terminator answering the request line with a grant
// assumes the request is level and drops once mastership is taken
`timescale 1ns/1ps
module adms_term_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       req_in,
    input  wire logic [3:0] dly_in,
    output logic            gnt_out
);
    logic [3:0] wait_r;

    // grant only after a variable wait, so slow and prompt answers both occur
    always_ff @(posedge clk_in) begin
        if (rst_in || !req_in) begin
            wait_r  <= 4'h0;
            gnt_out <= 1'b0;
        end else if (wait_r >= dly_in) begin
            gnt_out <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

// >>> verif/tb_adaptor_microsequencer.sv
// tb_adaptor_microsequencer: self-checking bench for the microsequencer
// assumes the terminator model on the grant pin and ce held high
`timescale 1ns/1ps
`include "adms_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t ns: got %h, expected %h", $time, (a), (b)); end end
module tb_adaptor_microsequencer;
    import adms_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rdq = 1'b0, att = 1'b0;
    logic        swx = 1'b0, swr = 1'b0, flt = 1'b0, non_processor_grant, non_processor_request, mst, clr, prg, rse, fen, hit;
    logic        oclr = 1'b0;
    logic [7:0]  ra = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [8:0]  ent = 9'h000, csa, e, tgt;
    logic [3:0]  dly = 4'h0, opb, buffered_data_path, eopb = 4'h0;
    logic [2:0]  cnt;
    logic [11:0] opa, eopa = 12'h000;
    logic [63:0] rv;
    logic [5:0]  c;
    adms_cond_t  cnd = '0, k;
    adms_cw_t    cw, w;
    adms_strb_t  strb;
    int          err_total = 0, cmp_count = 0, n;

    initial begin
        forever #10 clk = ~clk;
    end

    adms_seq dut (.ref_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rdq), .reg_rdata_out(rdat),
        .cond_in(cnd), .att_req_in(att), .att_entry_in(ent), .opreg_clr_in(oclr),
        .sw_xfer_in(swx), .sw_read_in(swr), .npg_in(non_processor_grant), .fault_in(flt), .npr_out(non_processor_request),
        .pb_master_out(mst), .pb_count_out(cnt), .cw_out(cw), .cs_addr_out(csa),
        .strb_out(strb), .opa_out(opa), .opb_out(opb), .bdp_num_out(buffered_data_path),
        .clr_xfer_err_out(clr), .purge_out(prg), .reg_strobe_en_out(rse),
        .fault_en_out(fen));
    adms_term_model term (.clk_in(clk), .rst_in(rst), .req_in(non_processor_request), .dly_in(dly),
        .gnt_out(non_processor_grant));

    function automatic logic [8:0] exp_nxt(input logic [5:0] c, input logic [8:0] n,
                                           input adms_cond_t k, input logic [1:0] ms);
        logic [23:0] tw;
        logic [3:0]  o;
        tw = {k.intr_rlsd, k.vec_full, k.ba_sel[2], k.pa_sel[2], k.transmit_parity_bit, 1'b0, k.cnt_full,
              k.tcnt[4], k.purge_rqd, k.purge_ok, k.rd_failsafe, k.byte_off, k.io_page,
              k.parity_err, k.msyn_rlsd, k.addr[1], k.ack, k.bdp_active, 1'b0, k.data_xfer,
              k.ext_func, k.dp_nonzero, k.bp_req, 1'b0};
        o = 4'h0;
        if (c <= 6'o27) begin
            o = {3'h0, tw[c[4:0]]};
        end else begin
            case (c)
                6'o40: o = {2'h0, k.path_addr};
                6'o41: o = {2'h0, k.bp_data_hi};
                6'o42: o = {2'h0, k.pa_sel[1:0]};
                6'o43: o = {2'h0, k.conf};
                6'o45: o = {2'h0, k.addr[1:0]};
                6'o46: o = {2'h0, k.pf_rcvd, k.rd_failsafe};
                6'o47: o = {2'h0, k.rd_rcvd, k.rd_failsafe};
                6'o51: o = {2'h0, ms};
                6'o52: o = {2'h0, k.ba_sel[1:0]};
                6'o70: o = {1'b0, k.byte_off, k.addr[2:1]};
                6'o71: o = {k.byte_off, k.addr};
                default: o = 4'h0;
            endcase
        end
        return n + {5'h0, o};
    endfunction

    function automatic logic [3:0] exp_bdp(input logic [1:0] s, input adms_cond_t k);
        case (s)
            2'd0: return k.map_dp;
            2'd1: return k.reg_addr;
            2'd2: return 4'h0;
            default: return k.tcnt[4:1];
        endcase
    endfunction

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        ra <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        ra <= a;
        rdq <= 1'b1;
        @(posedge clk);
        rdq <= 1'b0;
        #1;
        v = rdat;
    endtask

    task automatic ldw(input logic [8:0] a, input adms_cw_t v);
        wreg(`ADMS_OFS_INDEX, {23'h0, a});
        wreg(`ADMS_OFS_LO, v[31:0]);
        wreg(`ADMS_OFS_HI, {20'h0, v[43:32]});
    endtask

    task automatic bus(input logic r);
        @(posedge clk);
        dly <= 4'($urandom_range(0, 7));
        swx <= 1'b1;
        swr <= r;
        @(posedge clk);
        swx <= 1'b0;
        #1;
        `CHK(non_processor_request, 1'b1)
        n = 0;
        while (mst !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK({non_processor_request, cnt}, 4'h1)
        for (int j = 2; j < 8; j++) begin
            @(posedge clk);
            #1;
            `CHK(cnt, 3'(j))
        end
        @(posedge clk);
        #1;
        `CHK({mst, cnt}, 4'h0)
        hit = 1'b0;
        repeat (25) begin
            @(posedge clk);
            #1;
            if (csa === `ADMS_PRD_ENTRY) hit = 1'b1;
        end
        `CHK(hit, r)
    endtask

    task automatic test_done;
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        test_done();
    end

    initial begin
        void'($urandom(32'hf692));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({cw, csa}, {44'h0, `ADMS_IDLE_ADDR})
        n = 0;
        while (cw !== `ADMS_IDLE_WORD && n < 15) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK({cw, csa}, {`ADMS_IDLE_WORD, `ADMS_IDLE_ADDR})
        rreg(`ADMS_OFS_CTRL, d);
        `CHK(d[0], 1'b1)
        rreg(8'h24, d);
        `CHK(d, 32'h0)
        rreg(`ADMS_OFS_STAT, d);
        `CHK(d[14:9], 6'h08)
        for (int i = 0; i < 4; i++) begin
            wreg(`ADMS_OFS_DPW, {2'(i), 30'h0});
            `CHK({prg, clr}, 2'(i))
        end
        wreg(`ADMS_OFS_CFG, $urandom);
        `CHK(rse, 1'b1)
        wreg(`ADMS_OFS_DIAG, $urandom);
        `CHK(rse, 1'b1)
        @(posedge clk);
        flt <= 1'b1;
        @(posedge clk);
        flt <= 1'b0;
        #1;
        `CHK(fen, 1'b1)
        // falling through codes puts the register A load ahead of the micro-state branch
        for (int i = 63; i >= 0; i--) begin
            c = 6'(i);
            if (!((c <= 6'o27 && c != 6'o05 && c != 6'o22) || (c >= 6'o40 && c <= 6'o52
                && c != 6'o44 && c != 6'o50) || (c >= 6'o60 && c <= 6'o65) || c >= 6'o70
                && c <= 6'o71)) continue;
            rv = {$urandom, $urandom};
            w = adms_cw_t'(rv[43:0]);
            w.spare = 1'b0;
            w.br = c;
            w.next_address_field = (c == 6'o07) ? 9'h1ff : ({1'b0, w.next_address_field[7:0]} | 9'h010);
            rv = {$urandom, $urandom};
            k = adms_cond_t'(rv[$bits(adms_cond_t)-1:0]);
            if (c == 6'o07) k.ack = 1'b1;
            tgt = exp_nxt(c, w.next_address_field, k, eopa[11:10]);
            e = 9'h180 + 9'(i);
            ldw(tgt, adms_cw_t'(44'h003));
            ldw(e, w);
            @(posedge clk);
            cnd <= k;
            ent <= e;
            att <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (csa !== e && n < 40);
            `CHK({cw, csa}, {w, e})
            @(posedge clk);
            att <= 1'b0;
            #1;
            if (c == 6'o63) eopa = {w.op[15:5], w.op[2]};
            if (c == 6'o64) eopb = w.op[15:12];
            `CHK(strb, adms_strb_t'((c >= 6'o60 && c <= 6'o65) ? 6'h20 >> (c - 6'o60) : 6'h0))
            `CHK({opa, opb}, {eopa, eopb})
            @(posedge clk);
            #1;
            `CHK(buffered_data_path, exp_bdp(w.op[1:0], k))
            repeat (8) @(posedge clk);
            #1;
            `CHK(csa, tgt)
        end
        bus(1'b0);
        bus(1'b1);
        @(posedge clk);
        oclr <= 1'b1;
        @(posedge clk);
        oclr <= 1'b0;
        #1;
        `CHK({opa, opb}, 16'h0)
        test_done();
    end
endmodule
